/* rtl/cmp_port.sv */
// command interpreter for connection and virtual channel memory
// assumes one request per cycle from a PCI or microprocessor front end,
// already sorted into memory space; single clock, synchronous inputs
// Operation
// - four 2K regions, slot and stream addressed
// - regions: even, odd, local low, local high
// - bursts advance through consecutive entries
// - all byte enables off skips entry
// - address bit 15 means reset page
// - reset page clears valid of selected regions
// - make/break write, query read returns entry
// - query bit 27 shows connection valid
// - vc connection needs cm and vc writes
// - vc entry: static and scratchpad parts
// - any vc write zeroes current offset
// - vc write, static and scratch reads
// - micro bus: telephony only, vc diagnostic
// - diagnostic setting opens vc memory
// - micro bus assembles entries via holding
// - other spaces use plain direct access
// - byte 00-10 hold, 11 commits
// - word 0X holds, 1X commits
// - physical address: slot, select, stream
// - micro bus vc access off by default, bit 3; pci always open
`include "cmp_defines.svh"
module cmp_port #(
    parameter int VC_AW = 8
) (
    input  wire logic             ref_clk,
    input  wire logic             sys_rst,
    input  wire logic             bus_is_pci,
    input  wire logic             mp_byte_mode,
    input  wire logic [7:0]       misc_diagnostics_setting,
    input  wire logic             req_valid,
    output logic                  req_ready,
    input  wire cmp_pkg::cmp_req_t req,
    output logic                  rsp_valid,
    output cmp_pkg::cmp_rsp_t     rsp,
    input  wire logic             dir_ready,
    output logic                  dir_valid,
    output cmp_pkg::cmp_req_t     dir_req,
    input  wire logic [12:0]      lk_addr,
    output logic [31:0]           lk_entry,
    output logic                  lk_active,
    output logic                  sweep_busy
);
    import cmp_pkg::*;

    localparam int VC_N = 1 << VC_AW;
    localparam int CM_N = `CMP_PAGES << `CMP_PAGE_AW;

    if (VC_AW < 1 || VC_AW > 12) begin : g_chk
        $error("VC_AW must lie in 1..12");
    end

    // linear word address -> region and index inside it
    function automatic logic [12:0] cm_loc(input logic [12:0] la);
        logic [1:0] pg;
        logic [3:0] st;
        pg = la[5] ? {1'b1, la[4]} : {1'b0, la[0]};
        st = la[5] ? la[3:0] : la[4:1];
        return {pg, la[12:6], st};
    endfunction : cm_loc

    function automatic logic [31:0] be_merge(input logic [31:0] old,
                                             input logic [31:0] nw,
                                             input logic [3:0]  be);
        logic [31:0] r;
        r = old;
        for (int i = 0; i < 4; i++) begin
            if (be[i]) begin
                r[8*i +: 8] = nw[8*i +: 8];
            end
        end
        return r;
    endfunction : be_merge

    // micro bus reads return one lane of the entry
    function automatic logic [31:0] lane_sel(input logic [31:0] e,
                                             input logic [1:0]  lo,
                                             input logic        pci,
                                             input logic        byt);
        logic [31:0] r;
        r = e;
        if (!pci && byt) begin
            r = {24'h00_0000, e[{lo, 3'b000} +: 8]};
        end else if (!pci) begin
            r = {16'h0000, lo[1] ? e[31:16] : e[15:0]};
        end
        return r;
    endfunction : lane_sel

    logic [31:0]       cm_r [CM_N];
    logic [31:0]       vcs_r [VC_N];
    logic [31:0]       vcp_r [VC_N];
    logic [VC_N-1:0]   vc_wr_r, vc_wr_nxt;
    cmp_state_t        state_r, state_nxt;
    logic [10:0]       cnt_r, cnt_nxt;
    logic [3:0]        mask_r, mask_nxt;
    logic [23:0]       hold_r, hold_nxt;
    logic [12:0]       burst_r, burst_nxt;
    logic              rsp_valid_r, rsp_valid_nxt;
    cmp_rsp_t          rsp_r, rsp_nxt;
    logic              dir_valid_r, dir_valid_nxt;
    cmp_req_t          dir_req_r, dir_req_nxt;

    logic              taken, final_wr, vc_ok, cm_we, vc_we;
    logic [12:0]       la, ci;
    logic [1:0]        lo;
    logic [31:0]       asm_d, cm_old, cm_wd, vc_old, vc_wd;
    logic [3:0]        be_eff;
    logic [VC_AW-1:0]  vi;
    logic              vpart;
    logic [31:0]       lk_e;

    assign vc_ok = bus_is_pci || misc_diagnostics_setting[`CMP_DIAG_VCM_BIT];
    assign req_ready = (req.space == CMP_SP_CM) ? (state_r == CMP_ST_IDLE) :
                       (req.space == CMP_SP_DIRECT) ? dir_ready : 1'b1;
    assign taken = req_valid && req_ready;
    assign lo = req.addr[1:0];
    // the host must keep holding-first order; a final write uses what is held
    assign final_wr = bus_is_pci || (mp_byte_mode ? (lo == 2'b11) : lo[1]);
    assign asm_d = bus_is_pci ? req.wdata :
                   mp_byte_mode ? {req.wdata[7:0], hold_r} :
                   {req.wdata[15:0], hold_r[15:0]};
    assign be_eff = bus_is_pci ? req.be : `CMP_BE_ALL;
    assign la = (req.first || !bus_is_pci) ? req.addr[`CMP_LA_LSB +: 13] : 13'(burst_r + 13'h0001);
    assign ci = cm_loc(la);
    assign cm_old = cm_r[ci];
    assign vi = req.addr[`CMP_VC_IDX_LSB +: VC_AW];
    assign vpart = req.addr[`CMP_VC_PART_BIT];
    assign vc_old = vpart ? vcp_r[vi] : vcs_r[vi];

    always_comb begin
        state_nxt = state_r;
        cnt_nxt = cnt_r;
        mask_nxt = mask_r;
        hold_nxt = hold_r;
        burst_nxt = burst_r;
        vc_wr_nxt = vc_wr_r;
        rsp_valid_nxt = 1'b0;
        rsp_nxt = '0;
        dir_valid_nxt = 1'b0;
        dir_req_nxt = dir_req_r;
        cm_we = 1'b0;
        cm_wd = cm_old;
        vc_we = 1'b0;
        vc_wd = vc_old;
        unique case (state_r)
            CMP_ST_SWEEP: begin
                cnt_nxt = 11'(cnt_r + 11'h001);
                if (cnt_r == `CMP_PAGE_LAST) begin
                    state_nxt = CMP_ST_IDLE;
                end
            end
            CMP_ST_IDLE: begin
            end
        endcase
        if (taken && req.write && !final_wr && req.space != CMP_SP_DIRECT) begin
            if (mp_byte_mode) begin
                hold_nxt[{lo, 3'b000} +: 8] = req.wdata[7:0];
            end else begin
                hold_nxt[15:0] = req.wdata[15:0];
            end
        end
        if (taken) begin
            unique case (req.space)
                CMP_SP_CM: begin
                    rsp_valid_nxt = 1'b1;
                    burst_nxt = la;
                    if (req.addr[`CMP_RSTPG_BIT]) begin
                        if (!req.write) begin
                            rsp_nxt.err = 1'b1;
                        end else if (final_wr) begin
                            state_nxt = CMP_ST_SWEEP;
                            mask_nxt = asm_d[3:0];
                            cnt_nxt = '0;
                        end
                    end else if (req.write) begin
                        if (final_wr && be_eff != 4'h0) begin
                            cm_we = 1'b1;
                            cm_wd = be_merge(cm_old, asm_d, be_eff);
                        end
                    end else begin
                        rsp_nxt.rdata = lane_sel(cm_old, lo, bus_is_pci, mp_byte_mode);
                    end
                end
                CMP_SP_VC: begin
                    rsp_valid_nxt = 1'b1;
                    if (!vc_ok) begin
                        rsp_nxt.err = 1'b1;
                    end else if (req.write) begin
                        if (final_wr && be_eff != 4'h0) begin
                            vc_we = 1'b1;
                            vc_wd = be_merge(vc_old, asm_d, be_eff);
                            vc_wr_nxt[vi] = 1'b1;
                        end
                    end else begin
                        rsp_nxt.rdata = lane_sel(vc_old, lo, bus_is_pci, mp_byte_mode);
                    end
                end
                CMP_SP_DIRECT: begin
                    dir_valid_nxt = 1'b1;
                    dir_req_nxt = req;
                end
                default: begin
                    rsp_valid_nxt = 1'b1;
                    rsp_nxt.err = 1'b1;
                end
            endcase
        end
    end

    always_ff @(posedge ref_clk or posedge sys_rst) begin
        if (sys_rst) begin
            state_r <= CMP_ST_SWEEP;
            cnt_r <= '0;
            mask_r <= `CMP_PG_MASK_ALL;
            hold_r <= '0;
            burst_r <= '0;
            vc_wr_r <= '0;
            rsp_valid_r <= 1'b0;
            rsp_r <= '0;
            dir_valid_r <= 1'b0;
            dir_req_r <= '0;
        end else begin
            state_r <= state_nxt;
            cnt_r <= cnt_nxt;
            mask_r <= mask_nxt;
            hold_r <= hold_nxt;
            burst_r <= burst_nxt;
            vc_wr_r <= vc_wr_nxt;
            rsp_valid_r <= rsp_valid_nxt;
            rsp_r <= rsp_nxt;
            dir_valid_r <= dir_valid_nxt;
            dir_req_r <= dir_req_nxt;
        end
    end

    // storage holds no reset; validity is cleared by the sweep instead
    always_ff @(posedge ref_clk) begin
        if (state_r == CMP_ST_SWEEP) begin
            for (int p = 0; p < `CMP_PAGES; p++) begin
                if (mask_r[p]) begin
                    cm_r[{2'(p), cnt_r}][`CMP_VALID_BIT] <= 1'b0;
                end
            end
        end
        if (cm_we) begin
            cm_r[ci] <= cm_wd;
        end
        if (vc_we) begin
            if (vpart) begin
                vcp_r[vi] <= {vc_wd[31:`CMP_OFS_W], {`CMP_OFS_W{1'b0}}};
            end else begin
                vcs_r[vi] <= vc_wd;
                vcp_r[vi][`CMP_OFS_W-1:0] <= '0;
            end
        end
    end

    // datapath view: vc entries count only once both memories are written, and only while bus_is_pci is high
    assign lk_e = cm_r[cm_loc(lk_addr)];
    assign lk_entry = lk_e;
    assign lk_active = lk_e[`CMP_VALID_BIT] && (!lk_e[`CMP_VCKIND_BIT] ||
                       (bus_is_pci && vc_wr_r[lk_e[VC_AW-1:0]]));
    assign sweep_busy = (state_r == CMP_ST_SWEEP);
    assign rsp_valid = rsp_valid_r;
    assign rsp = rsp_r;
    assign dir_valid = dir_valid_r;
    assign dir_req = dir_req_r;

    default clocking cb @(posedge ref_clk); endclocking
    default disable iff (sys_rst);

    sequence s_cm_take;
        taken && req.space == CMP_SP_CM && !req.addr[`CMP_RSTPG_BIT];
    endsequence
    sequence s_query;
        s_cm_take ##0 (!req.write && bus_is_pci);
    endsequence

    a_sweep_stall: assert property (sweep_busy |-> !taken || req.space != CMP_SP_CM)
        else $error("cm access taken during sweep");
    a_query_valid: assert property (s_query |=> rsp_valid && !rsp.err &&
        rsp.rdata[`CMP_VALID_BIT] == $past(cm_old[`CMP_VALID_BIT]))
        else $error("query valid bit wrong");
    // the entry itself must come through a skipped phase untouched
    a_skip_phase: assert property (s_cm_take ##0 (req.write && be_eff == 4'h0) |->
        !cm_we ##1 cm_r[$past(ci)] == $past(cm_old))
        else $error("skipped phase wrote entry");
    a_rstpg_start: assert property (taken && req.space == CMP_SP_CM && bus_is_pci &&
        req.write && req.addr[`CMP_RSTPG_BIT] |=> sweep_busy && cnt_r == 11'h000 &&
        mask_r == $past(req.wdata[3:0]))
        else $error("reset page not started");
    a_sweep_step: assert property (sweep_busy && cnt_r != `CMP_PAGE_LAST |=>
        sweep_busy && cnt_r == 11'($past(cnt_r) + 11'h001))
        else $error("sweep counter stalled");
    a_vc_offset: assert property (vc_we |=> vcp_r[$past(vi)][`CMP_OFS_W-1:0] == '0)
        else $error("vc offset not zeroed");
    a_mp_hold: assert property (s_cm_take ##0 (req.write && !bus_is_pci && mp_byte_mode &&
        lo != 2'b11) |-> !cm_we)
        else $error("byte hold committed");
    a_mp_commit: assert property (s_cm_take ##0 (req.write && !bus_is_pci && !mp_byte_mode &&
        lo[1]) |-> cm_we && cm_wd == {req.wdata[15:0], hold_r[15:0]})
        else $error("word commit wrong");
    a_vc_blocked: assert property (taken && req.space == CMP_SP_VC && !bus_is_pci &&
        !misc_diagnostics_setting[`CMP_DIAG_VCM_BIT] |-> !vc_we ##1 rsp_valid && rsp.err)
        else $error("vc open without diagnostic");
    a_dir_pass: assert property (taken && req.space == CMP_SP_DIRECT |=>
        dir_valid && !rsp_valid && dir_req == $past(req))
        else $error("direct access not passed");
endmodule : cmp_port

/* rtl/cmp_defines.svh */
// constants of the connection memory programming port: bit positions,
// reset values and counts; included by bare name wherever needed
`ifndef CMP_DEFINES_SVH
`define CMP_DEFINES_SVH
`define CMP_VALID_BIT    27
`define CMP_VCKIND_BIT   26
`define CMP_RSTPG_BIT    15
`define CMP_DIAG_VCM_BIT 3
`define CMP_LA_LSB       2
`define CMP_VC_PART_BIT  2
`define CMP_VC_IDX_LSB   3
`define CMP_OFS_W        16
`define CMP_PAGES        4
`define CMP_PAGE_AW      11
`define CMP_PAGE_LAST    11'h07ff
`define CMP_PG_MASK_ALL  4'hf
`define CMP_BE_ALL       4'hf
`endif

/* rtl/cmp_pkg.sv */
// types shared by the connection memory programming port
// assumes the bus front ends have already classified each access
package cmp_pkg;
    typedef enum logic [1:0] {
        CMP_SP_CM,
        CMP_SP_VC,
        CMP_SP_DIRECT
    } cmp_space_t;

    typedef struct packed {
        cmp_space_t  space;
        logic        write;
        logic        first;
        logic [15:0] addr;
        logic [3:0]  be;
        logic [31:0] wdata;
    } cmp_req_t;

    typedef struct packed {
        logic [31:0] rdata;
        logic        err;
    } cmp_rsp_t;

    typedef enum logic {
        CMP_ST_SWEEP,
        CMP_ST_IDLE
    } cmp_state_t;
endpackage : cmp_pkg

/* tb/cmp_dir_sink.sv */
// partner model: downstream target of the plain direct accesses
// assumes dir_valid pulses once for each request taken while dir_ready is high
module cmp_dir_sink (
    input  wire logic              ref_clk,
    input  wire logic              sys_rst,
    input  wire logic              slow,
    input  wire logic              dir_valid,
    input  wire cmp_pkg::cmp_req_t dir_req,
    output logic                   dir_ready,
    output logic [7:0]             got_cnt
);
    timeunit 1ns;
    timeprecision 1ns;
    import cmp_pkg::*;
    logic [1:0] phase_r;
    always_ff @(posedge ref_clk or posedge sys_rst) begin
        if (sys_rst) begin
            phase_r <= 2'h0;
            got_cnt <= 8'h00;
        end else begin
            phase_r <= phase_r + 2'h1;
            if (dir_valid) begin
                got_cnt <= got_cnt + 8'h01;
            end
        end
    end
    // slow mode takes one cycle in four, so the requester must hold its request
    assign dir_ready = !slow || (phase_r == 2'h3);
endmodule : cmp_dir_sink

/* tb/cmp_port_test.sv */
// self-checking bench for the connection memory programming port
// assumes the design asserts its own rules; a sink model stands on the direct side
module cmp_port_test;
    timeunit 1ns;
    timeprecision 1ns;
    import cmp_pkg::*;
    logic ref_clk, sys_rst, bus_is_pci, mp_byte_mode, req_valid, req_ready;
    logic rsp_valid, dir_ready, dir_valid, lk_active, sweep_busy, slow;
    logic [7:0] misc_diagnostics_setting, got_cnt;
    logic [12:0] lk_addr;
    logic [31:0] lk_entry;
    cmp_req_t req, dir_req;
    cmp_rsp_t rsp;
    int n_errors = 0;
    int checked = 0;
    cmp_port DUT (.ref_clk(ref_clk), .sys_rst(sys_rst), .bus_is_pci(bus_is_pci),
        .mp_byte_mode(mp_byte_mode), .misc_diagnostics_setting(misc_diagnostics_setting),
        .req_valid(req_valid), .req_ready(req_ready), .req(req), .rsp_valid(rsp_valid),
        .rsp(rsp), .dir_ready(dir_ready), .dir_valid(dir_valid), .dir_req(dir_req),
        .lk_addr(lk_addr), .lk_entry(lk_entry), .lk_active(lk_active),
        .sweep_busy(sweep_busy));
    cmp_dir_sink sink (.ref_clk(ref_clk), .sys_rst(sys_rst), .slow(slow),
        .dir_valid(dir_valid), .dir_req(dir_req), .dir_ready(dir_ready), .got_cnt(got_cnt));
    always #50 ref_clk = ~ref_clk;
    task automatic complete_run;
        $display("checks %0d errors %0d", checked, n_errors);
        if (n_errors == 0 && checked > 0) begin
            $display("All checks passed");
        end else begin
            $display("Checks failed");
        end
        $finish;
    endtask : complete_run
    task automatic check(input string nm, input logic [31:0] exp, input logic [31:0] got);
        checked++;
        if (got !== exp) begin
            n_errors++;
            $display("Error %s expected %h seen %h", nm, exp, got);
        end
    endtask : check
    function automatic logic [15:0] ca(input logic [6:0] s, input logic l, input logic [4:0] t);
        return {1'b0, s, l, t, 2'b00};
    endfunction : ca
    // one request, held until taken; rsp or dir_valid is looked at in the answer cycle
    task automatic xfer(input cmp_space_t sp, input logic wr, input logic f,
                        input logic [15:0] a, input logic [3:0] b, input logic [31:0] d);
        int n;
        n = 0;
        // one idle edge between requests, so req_valid never changes twice at once
        @(posedge ref_clk);
        #10;
        req_valid = 1'b1;
        req = '{space: sp, write: wr, first: f, addr: a, be: b, wdata: d};
        // let the combinational ready settle on the new request before looking
        #1;
        while (req_ready !== 1'b1 && n < 3000) begin
            @(posedge ref_clk);
            #10;
            n++;
        end
        if (n == 3000) begin
            check("request taken", 1, 0);
            complete_run();
        end
        @(posedge ref_clk);
        #10;
        req_valid = 1'b0;
        if (sp == CMP_SP_DIRECT) begin
            check("dir_valid", 1, dir_valid);
        end else begin
            check("rsp_valid", 1, rsp_valid);
        end
    endtask : xfer
    task automatic peek(input logic [15:0] a, input logic [31:0] exp, input string nm);
        lk_addr = a[14:2];
        #1;
        check(nm, exp, lk_entry);
    endtask : peek
    task automatic t_reset_clear;
        check("busy after reset", 1, sweep_busy);
        req = '{space: CMP_SP_CM, write: 1'b0, first: 1'b1, addr: 16'h0000, be: 4'hf,
                wdata: 32'h0000_0000};
        check("cm ready in sweep", 0, req_ready);
        xfer(CMP_SP_CM, 1'b0, 1'b1, ca(7'h05, 1'b0, 5'h02), 4'hf, 32'h0000_0000);
        check("valid after reset", 0, rsp.rdata[27]);
        $display("test reset_clear done");
    endtask : t_reset_clear
    task automatic t_make_query;
        xfer(CMP_SP_CM, 1'b1, 1'b1, ca(7'h7f, 1'b1, 5'h1f), 4'hf, 32'h0800_1234);
        xfer(CMP_SP_CM, 1'b0, 1'b1, ca(7'h7f, 1'b1, 5'h1f), 4'hf, 32'h0000_0000);
        check("query data", 32'h0800_1234, rsp.rdata);
        xfer(CMP_SP_CM, 1'b0, 1'b1, 16'h8000, 4'hf, 32'h0000_0000);
        check("query bit15 err", 1, rsp.err);
        $display("test make_query done");
    endtask : t_make_query
    task automatic t_burst;
        xfer(CMP_SP_CM, 1'b1, 1'b1, ca(7'h07, 1'b0, 5'h01), 4'hf, 32'h0000_00aa);
        xfer(CMP_SP_CM, 1'b1, 1'b1, ca(7'h07, 1'b0, 5'h00), 4'hf, 32'h0800_0011);
        xfer(CMP_SP_CM, 1'b1, 1'b0, 16'h0000, 4'h0, 32'h0800_0022);
        xfer(CMP_SP_CM, 1'b1, 1'b0, 16'h0000, 4'hf, 32'h0800_0033);
        peek(ca(7'h07, 1'b0, 5'h00), 32'h0800_0011, "burst 0");
        peek(ca(7'h07, 1'b0, 5'h01), 32'h0000_00aa, "burst skip");
        peek(ca(7'h07, 1'b0, 5'h02), 32'h0800_0033, "burst 2");
        $display("test burst done");
    endtask : t_burst
    task automatic t_reset_page;
        int n;
        xfer(CMP_SP_CM, 1'b1, 1'b1, ca(7'h05, 1'b0, 5'h02), 4'hf, 32'h0800_0001);
        xfer(CMP_SP_CM, 1'b1, 1'b1, ca(7'h05, 1'b0, 5'h03), 4'hf, 32'h0800_0002);
        xfer(CMP_SP_CM, 1'b1, 1'b1, ca(7'h09, 1'b1, 5'h14), 4'hf, 32'h0800_0003);
        xfer(CMP_SP_CM, 1'b1, 1'b1, 16'h8000, 4'hf, 32'h0000_0001);
        check("sweep started", 1, sweep_busy);
        check("cm held off", 0, req_ready);
        n = 0;
        while (sweep_busy === 1'b1 && n < 3000) begin
            @(posedge ref_clk);
            #10;
            n++;
        end
        check("sweep length", 2048, n);
        peek(ca(7'h05, 1'b0, 5'h02), 32'h0000_0001, "even page cleared");
        peek(ca(7'h05, 1'b0, 5'h03), 32'h0800_0002, "odd page kept");
        peek(ca(7'h09, 1'b1, 5'h14), 32'h0800_0003, "local high kept");
        $display("test reset_page done");
    endtask : t_reset_page
    task automatic t_micro;
        logic [15:0] a;
        a = ca(7'h03, 1'b1, 5'h04);
        bus_is_pci = 1'b0;
        mp_byte_mode = 1'b1;
        xfer(CMP_SP_CM, 1'b1, 1'b1, a, 4'hf, 32'h0000_0011);
        xfer(CMP_SP_CM, 1'b1, 1'b1, a | 16'h0001, 4'hf, 32'h0000_0022);
        xfer(CMP_SP_CM, 1'b1, 1'b1, a | 16'h0002, 4'hf, 32'h0000_0033);
        lk_addr = a[14:2];
        #1;
        check("held not committed", 0, lk_entry[27]);
        xfer(CMP_SP_CM, 1'b1, 1'b1, a | 16'h0003, 4'hf, 32'h0000_008c);
        peek(a, 32'h8c33_2211, "byte commit");
        xfer(CMP_SP_CM, 1'b0, 1'b1, a | 16'h0003, 4'hf, 32'h0000_0000);
        check("byte read", 32'h0000_008c, rsp.rdata);
        mp_byte_mode = 1'b0;
        xfer(CMP_SP_CM, 1'b1, 1'b1, a, 4'hf, 32'h0000_5566);
        xfer(CMP_SP_CM, 1'b1, 1'b1, a | 16'h0002, 4'hf, 32'h0000_0877);
        peek(a, 32'h0877_5566, "word commit");
        xfer(CMP_SP_VC, 1'b1, 1'b1, 16'h0028, 4'hf, 32'h0000_0001);
        check("vc closed", 1, rsp.err);
        misc_diagnostics_setting = 8'h08;
        xfer(CMP_SP_VC, 1'b1, 1'b1, 16'h0028, 4'hf, 32'h0000_0001);
        check("vc open", 0, rsp.err);
        misc_diagnostics_setting = 8'h00;
        bus_is_pci = 1'b1;
        $display("test micro done");
    endtask : t_micro
    task automatic t_vc;
        xfer(CMP_SP_CM, 1'b1, 1'b1, ca(7'h01, 1'b0, 5'h01), 4'hf, 32'h0c00_0006);
        peek(ca(7'h01, 1'b0, 5'h01), 32'h0c00_0006, "vc cm entry");
        check("vc not yet active", 0, lk_active);
        xfer(CMP_SP_VC, 1'b1, 1'b1, 16'h0034, 4'hf, 32'habcd_00ff);
        xfer(CMP_SP_VC, 1'b1, 1'b1, 16'h0030, 4'hf, 32'h1234_5678);
        #1;
        check("vc active", 1, lk_active);
        xfer(CMP_SP_VC, 1'b0, 1'b1, 16'h0030, 4'hf, 32'h0000_0000);
        check("static read", 32'h1234_5678, rsp.rdata);
        xfer(CMP_SP_VC, 1'b0, 1'b1, 16'h0034, 4'hf, 32'h0000_0000);
        check("scratch read", 32'habcd_0000, rsp.rdata);
        $display("test vc done");
    endtask : t_vc
    task automatic t_direct;
        slow = 1'b1;
        xfer(CMP_SP_DIRECT, 1'b1, 1'b1, 16'h0100, 4'h3, 32'h0000_beef);
        check("direct addr", 32'h0000_0100, dir_req.addr);
        check("direct data", 32'h0000_beef, dir_req.wdata);
        xfer(CMP_SP_DIRECT, 1'b0, 1'b1, 16'h0104, 4'hf, 32'h0000_0000);
        @(posedge ref_clk);
        #10;
        check("direct count", 2, got_cnt);
        slow = 1'b0;
        $display("test direct done");
    endtask : t_direct
    initial begin
        ref_clk = 1'b0;
        sys_rst = 1'b1;
        bus_is_pci = 1'b1;
        mp_byte_mode = 1'b0;
        misc_diagnostics_setting = 8'h00;
        req_valid = 1'b0;
        req = '0;
        lk_addr = 13'h0000;
        slow = 1'b0;
        repeat (3) @(posedge ref_clk);
        #10;
        sys_rst = 1'b0;
        t_reset_clear();
        t_make_query();
        t_burst();
        t_reset_page();
        t_micro();
        t_vc();
        t_direct();
        complete_run();
    end
endmodule : cmp_port_test
